// ### pmsr_cfg.svh
/*
 pmsr_cfg.svh: register numbers, field positions, reset values and frame
 layout for the per-port management register set.
 Assumes it is included by bare name, and only after the timescale and
 nettype lines of the including file.
*/
`ifndef PMSR_CFG_SVH
`define PMSR_CFG_SVH

// register numbers on the management bus
`define PMSR_REG_CONTROL        5'h00
`define PMSR_REG_STATUS         5'h01
`define PMSR_REG_ID_HIGH        5'h02
`define PMSR_REG_ID_LOW         5'h03
`define PMSR_REG_ADVERTISE      5'h04
`define PMSR_REG_PARTNER        5'h05

// basic_control low bits
`define PMSR_CTL_XOVER_OFF      3
`define PMSR_CTL_FAULT_OFF      2
`define PMSR_CTL_TX_OFF         1
`define PMSR_CTL_INDICATOR_OFF  0
`define PMSR_CTL_HI             3
`define PMSR_CTL_RESET          4'h0

// basic_status bits
`define PMSR_STS_FOUR_PAIR      15
`define PMSR_STS_ABLE_HI        14
`define PMSR_STS_ABLE_LO        11
`define PMSR_STS_ABLE_VAL       4'hf
`define PMSR_STS_NEG_DONE       5
`define PMSR_STS_FAR_FAULT      4
`define PMSR_STS_NEG_ABLE       3
`define PMSR_STS_LINK           2
`define PMSR_STS_EXTENDED       0

// autoneg_advertise and partner_ability fields
`define PMSR_ADV_PAUSE          10
`define PMSR_ABLE_HI            8
`define PMSR_ABLE_LO            5
`define PMSR_SEL_HI             4
`define PMSR_SEL_LO             0
`define PMSR_SEL_VAL            5'h01
`define PMSR_ADV_PAUSE_RESET    1'h1
`define PMSR_ADV_ABLE_RESET     4'hf
`define PMSR_PARTNER_RESET      4'h0

// frame layout: header is start(2) op(2) phy(5) reg(5), sent msb first
`define PMSR_PREAMBLE_BITS      6'h20
`define PMSR_HDR_LAST           5'h0d
`define PMSR_TURN_LAST          5'h01
`define PMSR_DATA_LAST          5'h0f
`define PMSR_HDR_ST_HI          13
`define PMSR_HDR_ST_LO          12
`define PMSR_HDR_OP_HI          11
`define PMSR_HDR_OP_LO          10
`define PMSR_HDR_PHY_HI         9
`define PMSR_HDR_PHY_LO         5
`define PMSR_HDR_REG_HI         4
`define PMSR_HDR_REG_LO         0
`define PMSR_START_CODE         2'h1
`define PMSR_OP_READ            2'h2
`define PMSR_OP_WRITE           2'h1

`endif

// ### pmsr_host_model.sv
/*
 pmsr_host_model: management controller issuing one 64-bit-time frame per call.
 Assumes the bench resolves the data line with a pull-up; mdc idles low.
*/
`timescale 1ns/10ps
`default_nettype none

module pmsr_host_model (
    input  wire logic clk,
    input  wire logic mdioLine,
    output logic      mdc,
    output logic      hostOut,
    output logic      hostOe
);
    initial
    begin
        mdc = 1'h0;
        hostOut = 1'h1;
        hostOe = 1'h0;
    end

    // 8 clk per bus bit; data set while mdc low, read data taken at the rise
    task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regNum,
                        input logic [15:0] wrData, output logic [15:0] rdData);
        logic [63:0] frame;
        frame = {32'hffffffff, 2'h1, op, phy, regNum, 2'h2, wrData};
        rdData = 16'h0000;
        for (int k = 0; k < 64; k++)
        begin
            repeat (4) @(posedge clk);
            #1;
            mdc = 1'h0;
            hostOut = frame[63 - k];
            hostOe = !(op == 2'h2 && k >= 46);
            repeat (4) @(posedge clk);
            #1;
            mdc = 1'h1;
            if (k >= 48)
                rdData = {rdData[14:0], mdioLine};
        end
        repeat (4) @(posedge clk);
        #1;
        mdc = 1'h0;
        hostOe = 1'h0;
    endtask
endmodule

`default_nettype wire

// ### pmsr_pin_sync.sv
/*
 pmsr_pin_sync: two-flop synchroniser for a group of pins, with a rising
 edge pulse per pin taken from the synchronised level.
 Assumes the pins are asynchronous to clk and change far slower than clk.
*/
`timescale 1ns/10ps
`default_nettype none

module pmsr_pin_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise
);

    genvar g;

    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : gen_pin
            logic meta_ff;
            logic sync_ff;
            logic prev_ff;

            // meta_ff feeds sync_ff only
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                    prev_ff <= 1'b0;
                end
                else
                begin
                    meta_ff <= pinIn[g];
                    sync_ff <= meta_ff;
                    prev_ff <= sync_ff;
                end
            end

            assign level[g] = sync_ff;
            assign rise[g]  = sync_ff & ~prev_ff;
        end
    endgenerate

endmodule

`default_nettype wire

// ### pmsr_pkg.sv
/*
 pmsr_pkg: types shared by the management register set.
 Assumes nothing of its surroundings.
*/
`default_nettype none

package pmsr_pkg;

    // serial frame engine phases
    typedef enum logic [1:0]
    {
        PMSR_IDLE,
        PMSR_HDR,
        PMSR_TURN,
        PMSR_DATA
    } pmsr_frame_state_t;

endpackage

`default_nettype wire

// ### pmsr_regs.sv
/*
 pmsr_regs: per-port management register set behind the serial management
 bus (clock pin plus two-way data pin), with its frame engine.
 Assumes the bus clock is far slower than clk (at least 8 clk per period),
 that status and partner inputs come from logic on clk, and that phyAddr
 is held stable.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pmsr_cfg.svh"

module pmsr_regs #(
    parameter logic [15:0] ID_HIGH = 16'h5a5a,  // arbitrary value
    parameter logic [15:0] ID_LOW  = 16'ha5a5   // arbitrary value
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       mdc,
    input  wire logic       mdioIn,
    output logic            mdioOut,
    output logic            mdioOe,
    input  wire logic [4:0] phyAddr,
    input  wire logic       negotiationDone,
    input  wire logic       farEndFault,
    input  wire logic       linkUp,
    input  wire logic [3:0] partnerAble,
    output logic            crossoverAutoOff,
    output logic            farEndFaultOff,
    output logic            transmitOff,
    output logic            indicatorOff,
    output logic            advPause,
    output logic      [3:0] advAble
);

    import pmsr_pkg::*;

    // register number compare, used by read select and write decode
    function automatic logic regIs(input logic [4:0] addr, input logic [4:0] which);
        regIs = (addr == which);
    endfunction

    logic [1:0]        pinLevel;
    logic [1:0]        pinRise;
    logic              mdcRise;
    logic              mdioBit;

    pmsr_frame_state_t state_ff;
    pmsr_frame_state_t nxt_state;
    logic [5:0]        ones_ff;
    logic [5:0]        nxt_ones;
    logic [4:0]        cnt_ff;
    logic [4:0]        nxt_cnt;
    logic [13:0]       hdr_ff;
    logic [13:0]       nxt_hdr;
    logic [15:0]       data_ff;
    logic [15:0]       nxt_data;
    logic              isRead_ff;
    logic              nxt_isRead;
    logic [4:0]        regAddr_ff;
    logic [4:0]        nxt_regAddr;
    logic              mdioOut_ff;
    logic              nxt_mdioOut;
    logic              mdioOe_ff;
    logic              nxt_mdioOe;

    logic [`PMSR_CTL_HI:0] ctl_ff;
    logic                  pause_ff;
    logic [3:0]            able_ff;

    // both pins go through the same delay, so bit and clock stay aligned
    pmsr_pin_sync #(
        .WIDTH (2)
    ) u_pin_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .pinIn ({mdioIn, mdc}),
        .level (pinLevel),
        .rise  (pinRise)
    );

    assign mdcRise = pinRise[0];
    assign mdioBit = pinLevel[1];

    // header fields as they stand once the last header bit arrives
    wire [13:0] hdrWord   = {hdr_ff[12:0], mdioBit};
    wire        hdrStart  = hdrWord[`PMSR_HDR_ST_HI:`PMSR_HDR_ST_LO] == `PMSR_START_CODE;
    wire [1:0]  hdrOp     = hdrWord[`PMSR_HDR_OP_HI:`PMSR_HDR_OP_LO];
    wire        hdrMine   = hdrWord[`PMSR_HDR_PHY_HI:`PMSR_HDR_PHY_LO] == phyAddr;
    wire [4:0]  hdrReg    = hdrWord[`PMSR_HDR_REG_HI:`PMSR_HDR_REG_LO];
    wire        hdrRead   = hdrStart && hdrMine && (hdrOp == `PMSR_OP_READ);
    wire        hdrWrite  = hdrStart && hdrMine && (hdrOp == `PMSR_OP_WRITE);
    wire        preambleOk = (ones_ff == `PMSR_PREAMBLE_BITS);

    // register images
    logic [15:0] controlWord;
    logic [15:0] statusWord;
    logic [15:0] advertWord;
    logic [15:0] partnerWord;

    always_comb
    begin
        controlWord = 16'h0000;
        controlWord[`PMSR_CTL_HI:0] = ctl_ff;
    end

    always_comb
    begin
        statusWord = 16'h0000;
        statusWord[`PMSR_STS_FOUR_PAIR] = 1'b0;
        statusWord[`PMSR_STS_ABLE_HI:`PMSR_STS_ABLE_LO] = `PMSR_STS_ABLE_VAL;
        statusWord[`PMSR_STS_NEG_DONE]  = negotiationDone;
        statusWord[`PMSR_STS_FAR_FAULT] = farEndFault;
        statusWord[`PMSR_STS_NEG_ABLE]  = 1'b1;
        statusWord[`PMSR_STS_LINK]      = linkUp;
        statusWord[`PMSR_STS_EXTENDED]  = 1'b0;
    end

    always_comb
    begin
        advertWord = 16'h0000;
        advertWord[`PMSR_ADV_PAUSE] = pause_ff;
        advertWord[`PMSR_ABLE_HI:`PMSR_ABLE_LO] = able_ff;
        advertWord[`PMSR_SEL_HI:`PMSR_SEL_LO] = `PMSR_SEL_VAL;
    end

    always_comb
    begin
        partnerWord = 16'h0000;
        partnerWord[`PMSR_ABLE_HI:`PMSR_ABLE_LO] = partnerAble;
        partnerWord[`PMSR_SEL_HI:`PMSR_SEL_LO] = `PMSR_SEL_VAL;
    end

    // read select; unmapped register numbers read as zero
    wire [15:0] readWord =
        regIs(hdrReg, `PMSR_REG_CONTROL)   ? controlWord :
        regIs(hdrReg, `PMSR_REG_STATUS)    ? statusWord  :
        regIs(hdrReg, `PMSR_REG_ID_HIGH)   ? ID_HIGH     :
        regIs(hdrReg, `PMSR_REG_ID_LOW)    ? ID_LOW      :
        regIs(hdrReg, `PMSR_REG_ADVERTISE) ? advertWord  :
        regIs(hdrReg, `PMSR_REG_PARTNER)   ? partnerWord : 16'h0000;

    // frame engine; everything advances on a synchronised bus clock rise
    always_comb
    begin
        nxt_state   = state_ff;
        nxt_ones    = ones_ff;
        nxt_cnt     = cnt_ff;
        nxt_hdr     = hdr_ff;
        nxt_data    = data_ff;
        nxt_isRead  = isRead_ff;
        nxt_regAddr = regAddr_ff;
        nxt_mdioOut = mdioOut_ff;
        nxt_mdioOe  = mdioOe_ff;
        if (mdcRise)
        begin
            case (state_ff)
                PMSR_IDLE:
                begin
                    if (mdioBit)
                    begin
                        if (!preambleOk)
                        begin
                            nxt_ones = ones_ff + 6'h01;
                        end
                    end
                    else
                    begin
                        // a zero after a full preamble is the first start bit
                        nxt_ones = 6'h00;
                        if (preambleOk)
                        begin
                            nxt_state = PMSR_HDR;
                            nxt_hdr   = {13'h0, mdioBit};
                            nxt_cnt   = 5'h01;
                        end
                    end
                end
                PMSR_HDR:
                begin
                    nxt_hdr = hdrWord;
                    nxt_cnt = cnt_ff + 5'h01;
                    if (cnt_ff == `PMSR_HDR_LAST)
                    begin
                        nxt_cnt     = 5'h00;
                        nxt_isRead  = hdrRead;
                        nxt_regAddr = hdrReg;
                        nxt_data    = readWord;
                        // frames for another port or with bad codes are dropped
                        nxt_state   = (hdrRead || hdrWrite) ? PMSR_TURN : PMSR_IDLE;
                    end
                end
                PMSR_TURN:
                begin
                    nxt_cnt = cnt_ff + 5'h01;
                    if (cnt_ff == 5'h00)
                    begin
                        nxt_mdioOe  = isRead_ff;
                        nxt_mdioOut = 1'b0;
                    end
                    if (cnt_ff == `PMSR_TURN_LAST)
                    begin
                        nxt_cnt   = 5'h00;
                        nxt_state = PMSR_DATA;
                        if (isRead_ff)
                        begin
                            nxt_mdioOut = data_ff[15];
                            nxt_data    = {data_ff[14:0], 1'b0};
                        end
                    end
                end
                PMSR_DATA:
                begin
                    nxt_cnt     = cnt_ff + 5'h01;
                    nxt_data    = {data_ff[14:0], mdioBit};
                    nxt_mdioOut = isRead_ff ? data_ff[15] : 1'b0;
                    if (cnt_ff == `PMSR_DATA_LAST)
                    begin
                        nxt_cnt     = 5'h00;
                        nxt_state   = PMSR_IDLE;
                        nxt_mdioOe  = 1'b0;
                        nxt_mdioOut = 1'b0;
                    end
                end
                default:
                begin
                    nxt_state  = PMSR_IDLE;
                    nxt_mdioOe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff   <= PMSR_IDLE;
            ones_ff    <= 6'h00;
            cnt_ff     <= 5'h00;
            hdr_ff     <= 14'h0000;
            data_ff    <= 16'h0000;
            isRead_ff  <= 1'b0;
            regAddr_ff <= 5'h00;
            mdioOut_ff <= 1'b0;
            mdioOe_ff  <= 1'b0;
        end
        else
        begin
            state_ff   <= nxt_state;
            ones_ff    <= nxt_ones;
            cnt_ff     <= nxt_cnt;
            hdr_ff     <= nxt_hdr;
            data_ff    <= nxt_data;
            isRead_ff  <= nxt_isRead;
            regAddr_ff <= nxt_regAddr;
            mdioOut_ff <= nxt_mdioOut;
            mdioOe_ff  <= nxt_mdioOe;
        end
    end

    // write lands on the rise that carries the last data bit
    wire        wrFire  = mdcRise && (state_ff == PMSR_DATA) && (cnt_ff == `PMSR_DATA_LAST)
                          && !isRead_ff;
    wire [15:0] wrWord  = {data_ff[14:0], mdioBit};
    wire        wrCtl   = wrFire && regIs(regAddr_ff, `PMSR_REG_CONTROL);
    wire        wrAdv   = wrFire && regIs(regAddr_ff, `PMSR_REG_ADVERTISE);

    // only the writable fields are stored; other bits are rebuilt on read
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctl_ff   <= `PMSR_CTL_RESET;
            pause_ff <= `PMSR_ADV_PAUSE_RESET;
            able_ff  <= `PMSR_ADV_ABLE_RESET;
        end
        else
        begin
            if (wrCtl)
            begin
                ctl_ff <= wrWord[`PMSR_CTL_HI:0];
            end
            if (wrAdv)
            begin
                pause_ff <= wrWord[`PMSR_ADV_PAUSE];
                able_ff  <= wrWord[`PMSR_ABLE_HI:`PMSR_ABLE_LO];
            end
        end
    end

    assign crossoverAutoOff = ctl_ff[`PMSR_CTL_XOVER_OFF];
    assign farEndFaultOff   = ctl_ff[`PMSR_CTL_FAULT_OFF];
    assign transmitOff      = ctl_ff[`PMSR_CTL_TX_OFF];
    assign indicatorOff     = ctl_ff[`PMSR_CTL_INDICATOR_OFF];
    assign advPause         = pause_ff;
    assign advAble          = able_ff;
    assign mdioOut          = mdioOut_ff;
    assign mdioOe           = mdioOe_ff;

endmodule

`default_nettype wire

// ### pmsr_regs_checker.sv
/*
 pmsr_regs_checker: timing checks on the management pins and control outputs.
 Assumes it is bound into pmsr_regs and that mdc runs slower than clk/8.
*/
`timescale 1ns/10ps
`default_nettype none

module pmsr_regs_checker (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       mdc,
    input wire logic       mdioOut,
    input wire logic       mdioOe,
    input wire logic       crossoverAutoOff,
    input wire logic       farEndFaultOff,
    input wire logic       transmitOff,
    input wire logic       indicatorOff,
    input wire logic       advPause,
    input wire logic [3:0] advAble
);
    logic       mdcPrev_ff;
    logic [3:0] riseAge_ff;
    logic [4:0] oeRises_ff;
    logic       mdcRise;
    logic [3:0] nxt_riseAge;
    logic [4:0] nxt_oeRises;
    logic [8:0] ctlBits;
    logic       riseNear;

    assign mdcRise = mdc && !mdcPrev_ff;
    // age saturates so a long idle never wraps into the legal window
    assign nxt_riseAge = mdcRise ? 4'h0 : riseAge_ff + {3'h0, riseAge_ff != 4'hf};
    assign nxt_oeRises = mdioOe ? oeRises_ff + {4'h0, mdcRise} : 5'h00;
    assign ctlBits = {crossoverAutoOff, farEndFaultOff, transmitOff, indicatorOff,
                      advPause, advAble};
    // design reacts 2 to 3 clk after a pin rise; window leaves slack both ways
    assign riseNear = riseAge_ff inside {[4'h1:4'h6]};

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mdcPrev_ff <= 1'h0;
            riseAge_ff <= 4'hf;
            oeRises_ff <= 5'h00;
        end
        else
        begin
            mdcPrev_ff <= mdc;
            riseAge_ff <= nxt_riseAge;
            oeRises_ff <= nxt_oeRises;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    reset_ctl_a: assert property ($rose(rst_b) |-> ctlBits[8:5] == 4'h0)
        else $error("control bits not at reset values");
    reset_adv_a: assert property ($rose(rst_b) |-> ctlBits[4:0] == 5'h1f)
        else $error("advertise outputs not at reset values");
    ta_zero_a: assert property ($rose(mdioOe) |-> !mdioOut)
        else $error("turnaround bit not driven low");
    oe_edge_a: assert property ($changed(mdioOe) |-> riseNear)
        else $error("pin enable moved away from a bus clock rise");
    oe_span_a: assert property ($fell(mdioOe) |-> oeRises_ff == 5'h11)
        else $error("read drive did not last seventeen bus clocks");
    out_timing_a: assert property (mdioOe && $changed(mdioOut) |-> riseNear)
        else $error("read data changed away from a bus clock rise");
    out_hold_a: assert property (mdioOe && mdcRise |-> $stable(mdioOut) [*3])
        else $error("read data not held across the sampling rise");
    ctl_timing_a: assert property ($changed(ctlBits) |-> riseNear)
        else $error("control output changed outside a write");
    ctl_quiet_a: assert property ($changed(ctlBits) |-> !mdioOe)
        else $error("control output changed during a read");

    cover property ($rose(mdioOe));
    cover property ($changed(ctlBits));
    cover property ($fell(advPause));
endmodule

bind pmsr_regs pmsr_regs_checker chk_u (.clk, .rst_b, .mdc, .mdioOut, .mdioOe,
    .crossoverAutoOff, .farEndFaultOff, .transmitOff, .indicatorOff, .advPause, .advAble);

`default_nettype wire

// ### tb.sv
/*
 tb: register-level tests of pmsr_regs through the serial management frames.
 Assumes pmsr_host_model drives the bus; the data pin has a pull-up.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
    localparam logic [4:0]  PHY  = 5'h03;
    localparam logic [15:0] ID_H = 16'h3c3c;  // arbitrary value
    localparam logic [15:0] ID_L = 16'hc3c3;  // arbitrary value
    logic        clk, rst_b, mdc, mdioLine, mdioOut, mdioOe, hostOut, hostOe;
    logic        negotiationDone, farEndFault, linkUp;
    logic        crossoverAutoOff, farEndFaultOff, transmitOff, indicatorOff, advPause;
    logic [3:0]  partnerAble, advAble;
    logic [15:0] rd;
    logic [15:0] resetImg [6];
    int          failCount;
    int          comparisons;

    assign mdioLine = mdioOe ? mdioOut : (hostOe ? hostOut : 1'h1);

    pmsr_regs #(.ID_HIGH(ID_H), .ID_LOW(ID_L)) dut_u (.clk(clk), .rst_b(rst_b), .mdc(mdc),
        .mdioIn(mdioLine), .mdioOut(mdioOut), .mdioOe(mdioOe), .phyAddr(PHY),
        .negotiationDone(negotiationDone), .farEndFault(farEndFault), .linkUp(linkUp),
        .partnerAble(partnerAble), .crossoverAutoOff(crossoverAutoOff),
        .farEndFaultOff(farEndFaultOff), .transmitOff(transmitOff),
        .indicatorOff(indicatorOff), .advPause(advPause), .advAble(advAble));
    pmsr_host_model host_u (.clk(clk), .mdioLine(mdioLine), .mdc(mdc), .hostOut(hostOut),
        .hostOe(hostOe));

    always #20 clk = ~clk;

    task automatic summarize();
        if (failCount == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // control image: [8:5] control bits, [4] pause, [3:0] abilities
    task automatic checkCtl(input logic [15:0] exp);
        check({7'h00, crossoverAutoOff, farEndFaultOff, transmitOff, indicatorOff,
               advPause, advAble}, exp);
    endtask

    task automatic rdReg(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] v;
        host_u.xfer(2'h2, PHY, a, 16'h0000, v);
        check(v, exp);
    endtask

    task automatic wrReg(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] v;
        host_u.xfer(2'h1, PHY, a, d, v);
    endtask

    task automatic setIn(input logic [2:0] sts, input logic [3:0] able);
        @(posedge clk);
        #1;
        {negotiationDone, farEndFault, linkUp} = sts;
        partnerAble = able;
    endtask

    initial
    begin
        #2000000;
        failCount++;
        summarize();
    end

    initial
    begin
        clk = 1'h0;
        rst_b = 1'h0;
        {negotiationDone, farEndFault, linkUp} = 3'h0;
        partnerAble = 4'h0;
        failCount = 0;
        comparisons = 0;
        resetImg = '{16'h0000, 16'h7808, ID_H, ID_L, 16'h05e1, 16'h0001};
        repeat (10) @(posedge clk);
        #1;
        rst_b = 1'h1;
        repeat (6) @(posedge clk);
        checkCtl(16'h001f);
        for (int i = 0; i < 6; i++)
            rdReg(i[4:0], resetImg[i]);
        wrReg(5'h00, 16'hfffa);
        checkCtl(16'h015f);
        rdReg(5'h00, 16'h000a);
        wrReg(5'h00, 16'h0005);
        checkCtl(16'h00bf);
        rdReg(5'h00, 16'h0005);
        wrReg(5'h04, 16'hfaa0);
        checkCtl(16'h00a5);
        rdReg(5'h04, 16'h00a1);
        for (int i = 0; i < 8; i++)
        begin
            setIn(i[2:0], 4'h0);
            rdReg(5'h01, 16'h7808 | {10'h0, i[2], i[1], 1'h0, i[0], 2'h0});
        end
        setIn(3'h7, 4'ha);
        // partner abilities read straight from partnerAble, whatever done and link read
        rdReg(5'h01, 16'h783c);
        rdReg(5'h05, 16'h0141);
        setIn(3'h0, 4'h0);
        wrReg(5'h00, 16'h0000);
        wrReg(5'h04, 16'h05e0);
        for (int i = 1; i < 6; i++)
            wrReg(i[4:0], (i == 4) ? 16'h05e1 : 16'hffff);
        for (int i = 0; i < 6; i++)
            rdReg(i[4:0], resetImg[i]);
        host_u.xfer(2'h1, PHY ^ 5'h01, 5'h00, 16'h000f, rd);
        checkCtl(16'h001f);
        host_u.xfer(2'h2, PHY ^ 5'h01, 5'h01, 16'h0000, rd);
        check(rd, 16'hffff);
        wrReg(5'h10, 16'hffff);
        rdReg(5'h10, 16'h0000);
        wrReg(5'h00, 16'h000f);
        checkCtl(16'h01ff);
        @(posedge clk);
        #1;
        rst_b = 1'h0;
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1'h1;
        repeat (6) @(posedge clk);
        checkCtl(16'h001f);
        rdReg(5'h00, 16'h0000);
        summarize();
    end
endmodule

`default_nettype wire
